// *** logic/sac_adc_ctrl.sv ***
// Purpose: control of a 10-bit successive-approximation converter
// Assumes: comparator and mux macro clocked by clk, pins asynchronous
// Notes: result kept raw; justification applied when read
`timescale 1ns/1ps
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic stop_mode,
    input wire logic [7:0] port_out_data,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] port_read_data,
    output logic [7:0] analog_pin_sel,
    output logic [4:0] analog_mux_sel,
    output logic conv_power_on,
    output logic sample_hold,
    output logic [9:0] dac_code,
    input wire logic cmp_hi,
    output logic conv_irq
);
    logic [4:0] channel_select_field;
    logic conversion_irq_enable;
    logic continuous_conversion_bit;
    logic conversion_done_flag;
    logic [2:0] conv_clock_divider_bits;
    logic conv_clock_source_bit;
    logic result_format_bit_hi;
    logic result_format_bit_lo;
    sac_fmt_t fmt;
    sac_state_t state;
    logic [4:0] step;
    logic [8:0] div_cnt;
    logic [8:0] div_last;
    logic tick;
    logic [9:0] sar;
    logic [9:0] next_sar;
    logic [9:0] result;
    logic read_lock;
    logic pending;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic scr_wr;
    logic clk_wr;
    logic data_rd;
    logic done_evt;
    logic start_now;
    logic abort;
    logic [7:0] sel_now;
    logic [15:0] formatted;
    logic [4:0] ticks_seen;

    function automatic logic interlocked(input sac_fmt_t f);
        interlocked = (f != FMT_TRUNC);
    endfunction

    function automatic logic [15:0] format_result(input sac_fmt_t f,
                                                  input logic [9:0] r);
        case (f)
            FMT_LEFT: format_result = {r[9:2], r[1:0], 6'h00};
            FMT_RIGHT: format_result = {6'h00, r[9:8], r[7:0]};
            FMT_SIGNED: format_result = {~r[9], r[8:2], r[1:0], 6'h00};
            FMT_TRUNC: format_result = {8'h00, r[9:2]};
            default: format_result = 16'h0000;
        endcase
    endfunction

    assign fmt = sac_fmt_t'({result_format_bit_hi,
        result_format_bit_lo});
    assign formatted = format_result(fmt, result);
    assign scr_wr = reg_wr && (reg_addr == ADDR_SCR);
    assign clk_wr = reg_wr && (reg_addr == ADDR_CLK);
    assign data_rd = reg_rd
        && ((reg_addr == ADDR_RES_HI) || (reg_addr == ADDR_RES_LO));
    assign abort = scr_wr || stop_mode;
    // A write in the start cycle wins, so the new channel field is honoured
    assign start_now = (state == ST_IDLE) && pending && !stop_mode && !scr_wr
        && (channel_select_field != CHAN_OFF);
    assign done_evt = (state == ST_CONV) && tick
        && (step == CONV_LAST_STEP) && !abort;

    // Only codes 0..7 reach a pin; references and off leave the port alone
    always_comb begin
        sel_now = 8'h00;
        if (channel_select_field <= CHAN_EXT_LAST) begin
            sel_now[channel_select_field[2:0]] = 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_select_field <= CHAN_RST;
            conversion_irq_enable <= 1'b0;
            continuous_conversion_bit <= 1'b0;
        end else if (scr_wr) begin
            channel_select_field <= reg_wdata[SCR_CHAN_LSB +: 5];
            conversion_irq_enable <= reg_wdata[SCR_IEN_POS];
            continuous_conversion_bit <= reg_wdata[SCR_CONT_POS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_clock_divider_bits <= DIV_RST;
            conv_clock_source_bit <= CLK_SRC_RST;
            result_format_bit_hi <= 1'b0;
            result_format_bit_lo <= 1'b0;
        end else if (clk_wr) begin
            conv_clock_divider_bits <= reg_wdata[CLK_DIV_LSB +: 3];
            conv_clock_source_bit <= reg_wdata[CLK_SRC_POS];
            result_format_bit_hi <= reg_wdata[CLK_MODE_LSB + 1];
            result_format_bit_lo <= reg_wdata[CLK_MODE_LSB];
        end
    end

    // Converter clock: bus clock, or half of it, divided by 2^div
    assign div_last = 9'((9'h001 << conv_clock_divider_bits)
        << !conv_clock_source_bit) - 9'h001;
    assign tick = (div_cnt >= div_last);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 9'h000;
        end else if (tick) begin
            div_cnt <= 9'h000;
        end else begin
            div_cnt <= div_cnt + 9'h001;
        end
    end

    // Start request; a stop abort leaves it pending for the exit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (scr_wr) begin
            pending <= (reg_wdata[SCR_CHAN_LSB +: 5] != CHAN_OFF);
        end else if (stop_mode && (state == ST_CONV)) begin
            pending <= 1'b1;
        end else if (start_now) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            step <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_now) begin
                        state <= ST_CONV;
                        step <= 5'h00;
                    end
                end
                ST_CONV: begin
                    if (abort) begin
                        state <= ST_IDLE;
                    end else if (done_evt) begin
                        if (continuous_conversion_bit) begin
                            step <= 5'h00;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (tick) begin
                        step <= step + 5'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // One bit resolved per tick, MSB first
    always_comb begin
        next_sar = sar;
        if (tick && (step > SAR_FIRST_STEP) && (step <= SAR_LAST_STEP)
            && !cmp_hi) begin
            next_sar[4'(4'd11 - step[3:0])] = 1'b0;
        end
        if (tick && (step >= SAR_FIRST_STEP)
            && (step < SAR_LAST_STEP)) begin
            next_sar[4'(4'd10 - step[3:0])] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || (state != ST_CONV)) begin
            sar <= RES_ZERO;
        end else if (tick && (step == 5'h00)) begin
            sar <= RES_ZERO;
        end else begin
            sar <= next_sar;
        end
    end

    // Store unless a high-byte read awaits its low-byte partner
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result <= RES_ZERO;
        end else if (done_evt && !(read_lock && interlocked(fmt))) begin
            result <= sar;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_lock <= 1'b0;
        end else if (reg_rd && (reg_addr == ADDR_RES_LO)) begin
            read_lock <= 1'b0;
        end else if (reg_rd && (reg_addr == ADDR_RES_HI)
                     && interlocked(fmt)) begin
            read_lock <= 1'b1;
        end else if (!interlocked(fmt)) begin
            read_lock <= 1'b0;
        end
    end

    // Set wins over the clearing read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conversion_done_flag <= 1'b0;
        end else if (done_evt && !conversion_irq_enable) begin
            conversion_done_flag <= 1'b1;
        end else if (data_rd || conversion_irq_enable
                     || (scr_wr && reg_wdata[SCR_IEN_POS])) begin
            conversion_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_irq <= 1'b0;
        end else if (done_evt && conversion_irq_enable) begin
            conv_irq <= 1'b1;
        end else if (data_rd || scr_wr) begin
            conv_irq <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_SCR: reg_rdata <= {conversion_done_flag,
                    conversion_irq_enable, continuous_conversion_bit,
                    channel_select_field};
                ADDR_RES_HI: reg_rdata <= formatted[15:8];
                ADDR_RES_LO: reg_rdata <= formatted[7:0];
                ADDR_CLK: reg_rdata <= {conv_clock_divider_bits,
                    conv_clock_source_bit, result_format_bit_hi,
                    result_format_bit_lo, 2'b00};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Converter owns the selected pin; port logic keeps the rest
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            port_read_data <= 8'h00;
            analog_pin_sel <= 8'h00;
        end else begin
            pin_out <= port_out_data & ~sel_now;
            pin_oe <= port_dir & ~sel_now;
            port_read_data <= pin_sync & ~sel_now;
            analog_pin_sel <= sel_now;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_mux_sel <= CHAN_RST;
            conv_power_on <= 1'b0;
            sample_hold <= 1'b0;
            dac_code <= RES_ZERO;
        end else begin
            analog_mux_sel <= channel_select_field;
            conv_power_on <= (channel_select_field != CHAN_OFF)
                && !stop_mode;
            sample_hold <= (state == ST_CONV) && (step == 5'h00);
            dac_code <= next_sar;
        end
    end

    // Helper for the length check only
    always_ff @(posedge clk) begin
        if (!rst_n || start_now || (state != ST_CONV) || done_evt) begin
            ticks_seen <= 5'h00;
        end else if (tick) begin
            ticks_seen <= ticks_seen + 5'h01;
        end
    end

    property p_conv_len;
        @(posedge clk) disable iff (!rst_n)
        done_evt |-> ticks_seen == 5'd15;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion not sixteen ticks");

    property p_pin_owned;
        @(posedge clk) disable iff (!rst_n)
        (analog_pin_sel & (pin_oe | port_read_data | pin_out)) == 8'h00;
    endproperty
    a_pin_owned: assert property (p_pin_owned)
        else $error("selected pin leaks port logic");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
        (done_evt || (conversion_done_flag && !data_rd))
            && !conversion_irq_enable && !scr_wr |=> conversion_done_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("done flag not held");

    property p_flag_zero;
        @(posedge clk) disable iff (!rst_n)
        conversion_irq_enable && $past(conversion_irq_enable)
            |-> !conversion_done_flag;
    endproperty
    a_flag_zero: assert property (p_flag_zero)
        else $error("done flag set with interrupts on");

    property p_irq_set;
        @(posedge clk) disable iff (!rst_n)
        done_evt && conversion_irq_enable |=> conv_irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt not raised at end");

    property p_irq_clr;
        @(posedge clk) disable iff (!rst_n)
        (data_rd || scr_wr) && !done_evt |=> !conv_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("interrupt not cleared");

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        done_evt && read_lock && interlocked(fmt) |=> $stable(result);
    endproperty
    a_lock: assert property (p_lock)
        else $error("result stored while locked");

    property p_trunc;
        @(posedge clk) disable iff (!rst_n)
        done_evt && (fmt == FMT_TRUNC) |=> result == $past(sar);
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("truncation result not stored");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
        done_evt && !continuous_conversion_bit |=> state == ST_IDLE
            ##1 (state == ST_IDLE || $past(scr_wr, 2) || $past(pending));
    endproperty
    a_single: assert property (p_single)
        else $error("single mode did not idle");

    property p_cont;
        @(posedge clk) disable iff (!rst_n)
        done_evt && continuous_conversion_bit
            |=> state == ST_CONV && step == 5'h00;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode did not restart");

    property p_off_stop;
        @(posedge clk) disable iff (!rst_n)
        (channel_select_field == CHAN_OFF) || $past(stop_mode)
            |-> state == ST_IDLE;
    endproperty
    a_off_stop: assert property (p_off_stop)
        else $error("converter ran while off or stopped");
endmodule

// *** shared/sac_pkg.sv ***
// Purpose: constants and types for the converter control block
// Assumes: 8-bit register port, 10-bit successive-approximation core
// Notes: register offsets are word indices on the plain register port
package sac_pkg;
    localparam logic [1:0] ADDR_SCR = 2'h0;
    localparam logic [1:0] ADDR_RES_HI = 2'h1;
    localparam logic [1:0] ADDR_RES_LO = 2'h2;
    localparam logic [1:0] ADDR_CLK = 2'h3;

    localparam int SCR_DONE_POS = 7;
    localparam int SCR_IEN_POS = 6;
    localparam int SCR_CONT_POS = 5;
    localparam int SCR_CHAN_LSB = 0;
    localparam int CLK_DIV_LSB = 5;
    localparam int CLK_SRC_POS = 4;
    localparam int CLK_MODE_LSB = 2;

    localparam logic [4:0] CHAN_RST = 5'h1f;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic CLK_SRC_RST = 1'b0;

    localparam logic [4:0] CHAN_EXT_LAST = 5'h07;
    localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
    localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
    localparam logic [4:0] CHAN_OFF = 5'h1f;

    localparam int RES_BITS = 10;
    localparam logic [9:0] RES_FULL = 10'h3ff;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam logic [4:0] CONV_LAST_STEP = 5'h0f;
    localparam logic [4:0] SAR_FIRST_STEP = 5'h01;
    localparam logic [4:0] SAR_LAST_STEP = 5'h0b;

    typedef enum logic [1:0] {
        FMT_LEFT = 2'b00,
        FMT_RIGHT = 2'b01,
        FMT_SIGNED = 2'b10,
        FMT_TRUNC = 2'b11
    } sac_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } sac_state_t;
endpackage

// *** tb/sac_adc_ctrl_tb.sv ***
// Purpose: self-checking bench of the converter control block
// Assumes: register port strobes of one cycle, data one cycle after read
// Notes: fast clock setting used except for one slow timing run
`timescale 1ns/1ps
module sac_adc_ctrl_tb;
    import sac_pkg::*;
    logic clk = 1'b0;
    logic rst_n, reg_wr, reg_rd, stop_mode, conv_power_on, sample_hold;
    logic cmp_hi, conv_irq;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, port_out_data, port_dir, pin_in;
    logic [7:0] pin_out, pin_oe, port_read_data, analog_pin_sel, d;
    logic [4:0] analog_mux_sel;
    logic [9:0] dac_code, lvl;
    logic [15:0] hl;
    int error_cnt = 0;
    int compares = 0;
    int n;

    always #12.5 clk = ~clk;

    sac_adc_ctrl u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .stop_mode(stop_mode),
        .port_out_data(port_out_data), .port_dir(port_dir), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .port_read_data(port_read_data),
        .analog_pin_sel(analog_pin_sel), .analog_mux_sel(analog_mux_sel),
        .conv_power_on(conv_power_on), .sample_hold(sample_hold),
        .dac_code(dac_code), .cmp_hi(cmp_hi), .conv_irq(conv_irq));

    sac_analog_model u_ana (.clk(clk), .analog_mux_sel(analog_mux_sel),
        .analog_pin_sel(analog_pin_sel), .conv_power_on(conv_power_on),
        .dac_code(dac_code), .ch_level({8{lvl}}), .cmp_hi(cmp_hi));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic poll_done();
        logic [7:0] s;
        int i;
        s = 8'h00;
        i = 0;
        while (s[7] !== 1'b1 && i < 40) begin
            rd(ADDR_SCR, s);
            i++;
        end
        chk(s[7], 1'b1);
    endtask

    // Cycles from the end of a status write to the interrupt request
    task automatic wait_irq(input int lim, output int cnt);
        cnt = 0;
        while (conv_irq !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            #1 cnt++;
        end
    endtask

    task automatic conv_read(input logic [4:0] ch, output logic [15:0] r);
        logic [7:0] h;
        logic [7:0] l;
        wr(ADDR_SCR, {3'b000, ch});
        poll_done();
        rd(ADDR_RES_HI, h);
        rd(ADDR_RES_LO, l);
        r = {h, l};
    endtask

    function automatic logic [15:0] fmt(logic [1:0] m, logic [9:0] r);
        case (m)
            2'b00: fmt = {r[9:2], r[1:0], 6'h00};
            2'b01: fmt = {6'h00, r[9:8], r[7:0]};
            2'b10: fmt = {~r[9], r[8:2], r[1:0], 6'h00};
            default: fmt = {8'h00, r[9:2]};
        endcase
    endfunction

    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run is under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        stop_mode = 1'b0;
        port_out_data = 8'hff;
        port_dir = 8'hff;
        pin_in = 8'hff;
        lvl = 10'h2a5;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_SCR, d);
        chk(d, 8'h1f);
        rd(ADDR_CLK, d);
        chk(d, 8'h00);
        chk(conv_power_on, 1'b0);
        wr(ADDR_SCR, 8'h1f);
        repeat (60) @(posedge clk);
        rd(ADDR_SCR, d);
        chk(d, 8'h1f);
        // Slow divider near the recommended converter rate
        wr(ADDR_CLK, 8'h80);
        wr(ADDR_SCR, 8'h45);
        wait_irq(700, n);
        chk(n >= 15 * 32 && n <= 17 * 32 + 4, 1'b1);
        chk(analog_pin_sel, 8'h20);
        chk({pin_out, pin_oe}, 16'hdfdf);
        chk(port_read_data, 8'hdf);
        rd(ADDR_RES_HI, d);
        chk(d, 8'ha9);
        chk(conv_irq, 1'b0);
        rd(ADDR_RES_LO, d);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CLK, 8'h10 | 8'(m << 2));
            conv_read(5'h05, hl);
            chk(hl, fmt(2'(m), lvl));
            conv_read(5'h1d, hl);
            chk(hl, fmt(2'(m), 10'h3ff));
            conv_read(5'h1e, hl);
            chk(hl, fmt(2'(m), 10'h000));
            chk(conv_irq, 1'b0);
        end
        wr(ADDR_SCR, 8'h45);
        wait_irq(100, n);
        chk(n >= 15 && n <= 21, 1'b1);
        rd(ADDR_SCR, d);
        chk(d, 8'h45);
        wr(ADDR_SCR, 8'h45);
        chk(conv_irq, 1'b0);
        wait_irq(100, n);
        chk(conv_irq, 1'b1);
        rd(ADDR_RES_LO, d);
        wr(ADDR_CLK, 8'h14);
        conv_read(5'h05, hl);
        repeat (60) @(posedge clk);
        rd(ADDR_SCR, d);
        chk(d, 8'h05);
        wr(ADDR_SCR, 8'h05);
        repeat (60) @(posedge clk);
        rd(ADDR_SCR, d);
        chk(d, 8'h85);
        rd(ADDR_SCR, d);
        chk(d, 8'h85);
        rd(ADDR_RES_HI, d);
        rd(ADDR_SCR, d);
        chk(d, 8'h05);
        // Continuous mode with the high byte read first, low byte held back
        wr(ADDR_CLK, 8'h10);
        wr(ADDR_SCR, 8'h25);
        repeat (60) @(posedge clk);
        rd(ADDR_RES_HI, d);
        chk(d, 8'ha9);
        @(posedge clk) lvl <= 10'h15a;
        repeat (60) @(posedge clk);
        rd(ADDR_RES_LO, d);
        chk(d, 8'h40);
        repeat (60) @(posedge clk);
        rd(ADDR_RES_HI, d);
        chk(d, 8'h56);
        rd(ADDR_RES_LO, d);
        chk(d, 8'h80);
        wr(ADDR_CLK, 8'h1c);
        @(posedge clk) lvl <= 10'h2a5;
        repeat (60) @(posedge clk);
        rd(ADDR_RES_HI, d);
        chk(d, 8'h00);
        @(posedge clk) lvl <= 10'h15a;
        repeat (60) @(posedge clk);
        rd(ADDR_RES_LO, d);
        chk(d, 8'h56);
        wr(ADDR_SCR, 8'h05);
        repeat (60) @(posedge clk);
        rd(ADDR_RES_LO, d);
        repeat (60) @(posedge clk);
        rd(ADDR_SCR, d);
        chk(d, 8'h05);
        // Second write lands mid-conversion; only the restarted result counts
        wr(ADDR_SCR, 8'h05);
        conv_read(5'h05, hl);
        chk(hl, fmt(2'b11, lvl));
        wr(ADDR_SCR, 8'h05);
        repeat (2) @(posedge clk);
        #1 chk(sample_hold, 1'b1);
        repeat (3) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (60) @(posedge clk);
        rd(ADDR_SCR, d);
        chk(d, 8'h05);
        chk(conv_power_on, 1'b0);
        @(posedge clk) stop_mode <= 1'b0;
        poll_done();
        conclude();
    end
endmodule

// *** tb/sac_analog_model.sv ***
// Purpose: analog side of the converter: pins, references and comparator
// Assumes: ideal comparator, levels given by the bench per channel
// Notes: unconnected or unused inputs give a toggling comparator
`timescale 1ns/1ps
module sac_analog_model (
    input wire logic clk,
    input wire logic [4:0] analog_mux_sel,
    input wire logic [7:0] analog_pin_sel,
    input wire logic conv_power_on,
    input wire logic [9:0] dac_code,
    input wire logic [79:0] ch_level,
    output logic cmp_hi
);
    logic [9:0] vin;
    logic known;
    logic flip = 1'b0;

    // Unknown input must not settle to a lucky constant
    always @(posedge clk) begin
        flip <= ~flip;
    end

    always_comb begin
        vin = 10'h000;
        known = 1'b1;
        if (analog_mux_sel <= 5'h07
            && analog_pin_sel[analog_mux_sel[2:0]]) begin
            vin = ch_level[analog_mux_sel[2:0] * 10 +: 10];
        end else if (analog_mux_sel == 5'h1d) begin
            vin = 10'h3ff;
        end else if (analog_mux_sel == 5'h1e) begin
            vin = 10'h000;
        end else begin
            known = 1'b0;
        end
    end

    assign cmp_hi = (conv_power_on && known) ? (vin >= dac_code) : flip;
endmodule
